/* core/ais_status_indicator_monitor.sv */
// status leds, integrity self-test alarms and safety message button logic
// assumes monitor pins and the button are asynchronous; scheduler pulses share clock
`include "ais_status_defines.svh"
`timescale 1ns/1ps
`default_nettype none

module ais_status_indicator_monitor
    import ais_status_pkg::*;
#(
    parameter logic [23:0] LAMP_CYCLES = 24'(`LAMP_CYCLES),
    parameter logic [24:0] SRM_HOLD_CYCLES = 25'(`SRM_HOLD_CYCLES),
    parameter logic [23:0] SRM_RATE_CYCLES = 24'(`SRM_RATE_CYCLES),
    parameter logic [35:0] GPS_LOCK_CYCLES = 36'(`GPS_LOCK_CYCLES),
    parameter logic [31:0] REPORT_INTERVAL_CYCLES = 32'(`REPORT_INTERVAL_CYCLES)
) (
    input wire logic clock,
    input wire logic resetn,
    input wire mon_s monitor_pins,
    input wire logic srm_button,
    input wire logic report_sent,
    input wire logic tx_blocked_busy,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output led_s leds,
    output srm_s preset_safety_message,
    output logic tx_inhibit,
    output alarm_t alarm_event,
    output logic serial_txd
);

    localparam logic [8:0] BIT_CYCLES = 9'(`BIT_CYCLES);

    // lowest set alarm index
    function automatic logic [3:0] first_set(input alarm_t v);
        logic [3:0] idx;
        idx = 4'h0;
        for (int i = 11; i >= 0; i--) begin
            if (v[i]) begin
                idx = 4'(i);
            end
        end
        return idx;
    endfunction

    mon_s mon_meta_ff, mon_ff;
    logic btn_meta_ff, btn_ff;
    phase_e phase_ff;
    logic [23:0] lamp_cnt_ff;
    logic startup_done_ff, busy_warn_ff, app_running_ff;
    logic [32:0] since_report_ff;
    logic [35:0] nofix_cnt_ff;
    logic gps_nolock_ff;
    alarm_t alarm_ff, alarm_prev_ff, latch_ff, pend_ff;
    logic [31:0] interval_ff, text_lo_ff;
    logic [15:0] text_hi_ff;
    logic [24:0] hold_cnt_ff;
    logic [23:0] rate_cnt_ff;
    logic blue_ff, srm_clear_ff;
    logic [9:0] shift_ff;
    logic [3:0] bits_left_ff;
    logic [8:0] baud_cnt_ff;
    led_s leds_ff;
    srm_s srm_ff;
    logic tx_inhibit_ff, txd_ff, pready_ff, pslverr_ff;
    logic [31:0] prdata_ff, nxt_prdata;
    alarm_t alarm_evt_ff, nxt_alarm;
    logic gps_ready, missed, red_cond, yellow_cond, srm_fire, wr_hit, nxt_err;

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            mon_meta_ff <= '0;
            mon_ff <= '0;
            btn_meta_ff <= 1'b0;
            btn_ff <= 1'b0;
        end else begin
            mon_meta_ff <= monitor_pins;
            mon_ff <= mon_meta_ff;
            btn_meta_ff <= srm_button;
            btn_ff <= btn_meta_ff;
        end
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            phase_ff <= LAMP_ON1;
            lamp_cnt_ff <= 24'h00_0000;
        end else if (phase_ff != RUN) begin
            if (lamp_cnt_ff == LAMP_CYCLES - 24'h00_0001) begin
                lamp_cnt_ff <= 24'h00_0000;
                case (phase_ff)
                    LAMP_ON1: phase_ff <= LAMP_OFF1;
                    LAMP_OFF1: phase_ff <= LAMP_ON2;
                    LAMP_ON2: phase_ff <= RUN;
                    default: phase_ff <= RUN;
                endcase
            end else begin
                lamp_cnt_ff <= lamp_cnt_ff + 24'h00_0001;
            end
        end
    end

    assign gps_ready = mon_ff.gps_fix && !mon_ff.gps_fail;
    assign missed = startup_done_ff && (since_report_ff >= {interval_ff, 1'b0});

    // start-up ends on fix plus first report
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            startup_done_ff <= 1'b0;
        end else if (gps_ready && report_sent) begin
            startup_done_ff <= 1'b1;
        end
    end

    // time since last report, cleared by a report
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            since_report_ff <= 33'h0_0000_0000;
        end else if (report_sent || !startup_done_ff) begin
            since_report_ff <= 33'h0_0000_0000;
        end else if (!missed) begin
            since_report_ff <= since_report_ff + 33'h0_0000_0001;
        end
    end

    // busy channel warning, set wins, cleared when a report goes out
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            busy_warn_ff <= 1'b0;
        end else if (tx_blocked_busy) begin
            busy_warn_ff <= 1'b1;
        end else if (report_sent) begin
            busy_warn_ff <= 1'b0;
        end
    end

    // no gps lock for thirty minutes
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            nofix_cnt_ff <= 36'h0_0000_0000;
            gps_nolock_ff <= 1'b0;
        end else if (mon_ff.gps_fix) begin
            nofix_cnt_ff <= 36'h0_0000_0000;
            gps_nolock_ff <= 1'b0;
        end else if (nofix_cnt_ff >= GPS_LOCK_CYCLES - 36'h0_0000_0001) begin
            gps_nolock_ff <= 1'b1;
        end else begin
            nofix_cnt_ff <= nofix_cnt_ff + 36'h0_0000_0001;
        end
    end

    // self-test vector evaluated every cycle; one bit per test
    assign nxt_alarm = {gps_nolock_ff, mon_ff.lockout_expired, mon_ff.supply_bad,
        mon_ff.noise_high, mon_ff.gps_fail, mon_ff.cog_invalid, mon_ff.sog_invalid,
        mon_ff.gnss_unused, mon_ff.mismatch_high, mon_ff.rx2_unlock,
        mon_ff.rx1_unlock, mon_ff.tx_unlock};

    // alarm rising edges become event pulses
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            alarm_ff <= '0;
            alarm_prev_ff <= '0;
            alarm_evt_ff <= '0;
        end else begin
            alarm_ff <= nxt_alarm;
            alarm_prev_ff <= alarm_ff;
            alarm_evt_ff <= alarm_ff & ~alarm_prev_ff;
        end
    end

    assign red_cond = gps_nolock_ff || mon_ff.lockout_expired || mon_ff.supply_bad ||
        mon_ff.noise_high || mon_ff.mismatch_high;
    assign yellow_cond = !startup_done_ff || missed || !gps_ready || busy_warn_ff;

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            // leds dark and transmit inhibited in reset
            leds_ff <= '0;
            tx_inhibit_ff <= 1'b1;
        end else begin
            // inhibit transmit while sensor not ready
            tx_inhibit_ff <= !gps_ready;
            case (phase_ff)
                LAMP_ON1, LAMP_ON2: leds_ff <= '1;
                LAMP_OFF1: leds_ff <= '0;
                RUN: begin
                    leds_ff.blue <= blue_ff;
                    leds_ff.red <= red_cond;
                    leds_ff.yellow <= yellow_cond;
                    leds_ff.green <= startup_done_ff && app_running_ff;
                end
                default: leds_ff <= '0;
            endcase
        end
    end

    // button hold counter, fires once per press
    assign srm_fire = (hold_cnt_ff == SRM_HOLD_CYCLES) && (phase_ff == RUN);
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            hold_cnt_ff <= 25'h000_0000;
        end else if (!btn_ff) begin
            hold_cnt_ff <= 25'h000_0000;
        end else if (hold_cnt_ff <= SRM_HOLD_CYCLES) begin
            hold_cnt_ff <= hold_cnt_ff + 25'h000_0001;
        end
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            blue_ff <= 1'b0;
            rate_cnt_ff <= 24'h00_0000;
            srm_ff.req <= 1'b0;
        end else begin
            srm_ff.req <= 1'b0;
            if (srm_fire && !blue_ff && rate_cnt_ff == 24'h00_0000) begin
                srm_ff.req <= 1'b1;
                blue_ff <= 1'b1;
                rate_cnt_ff <= SRM_RATE_CYCLES - 24'h00_0001;
            end else begin
                if (srm_clear_ff) begin
                    blue_ff <= 1'b0;
                end
                if (rate_cnt_ff != 24'h00_0000) begin
                    rate_cnt_ff <= rate_cnt_ff - 24'h00_0001;
                end
            end
        end
    end

    // message type and payload presented with the request
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            srm_ff.msg_type <= 6'h00;
            srm_ff.text <= 48'h0000_0000_0000;
        end else begin
            srm_ff.msg_type <= `SRM_MSG_TYPE;
            srm_ff.text <= {text_lo_ff, text_hi_ff};
        end
    end

    // 8n1 transmitter sending one letter per pending alarm
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            pend_ff <= '0;
            shift_ff <= 10'h3ff;
            bits_left_ff <= 4'h0;
            baud_cnt_ff <= 9'h000;
            txd_ff <= 1'b1;
        end else if (bits_left_ff == 4'h0) begin
            txd_ff <= 1'b1;
            if (pend_ff != '0) begin
                shift_ff <= {1'b1, `ALARM_CHAR_BASE + 8'(first_set(pend_ff)), 1'b0};
                bits_left_ff <= 4'ha;
                baud_cnt_ff <= 9'h000;
                pend_ff <= (pend_ff & ~(12'h001 << first_set(pend_ff))) | alarm_evt_ff;
            end else begin
                pend_ff <= pend_ff | alarm_evt_ff;
            end
        end else begin
            pend_ff <= pend_ff | alarm_evt_ff;
            if (baud_cnt_ff == 9'h000) begin
                txd_ff <= shift_ff[0];
                shift_ff <= {1'b1, shift_ff[9:1]};
                baud_cnt_ff <= BIT_CYCLES - 9'h001;
            end else if (baud_cnt_ff == 9'h001 && bits_left_ff != 4'h0) begin
                baud_cnt_ff <= 9'h000;
                bits_left_ff <= bits_left_ff - 4'h1;
            end else begin
                baud_cnt_ff <= baud_cnt_ff - 9'h001;
            end
        end
    end

    // apb access decode
    assign wr_hit = psel && penable && pready_ff && pwrite;
    always_comb begin
        nxt_prdata = 32'h0000_0000;
        nxt_err = 1'b0;
        case (paddr)
            `REG_CTRL: nxt_prdata = {31'h0000_0000, app_running_ff};
            `REG_STATUS: nxt_prdata = {11'h000, tx_inhibit_ff, leds_ff, 3'h0,
                startup_done_ff, alarm_ff};
            `REG_ALARM_LATCH: nxt_prdata = {20'h0_0000, latch_ff};
            `REG_REPORT_INTERVAL: nxt_prdata = interval_ff;
            `REG_SRM_TEXT_LO: nxt_prdata = text_lo_ff;
            `REG_SRM_TEXT_HI: nxt_prdata = {16'h0000, text_hi_ff};
            `REG_SRM_TYPE: nxt_prdata = {26'h000_0000, `SRM_MSG_TYPE};
            default: nxt_err = 1'b1;
        endcase
    end

    // apb answer one cycle into the access phase
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            pready_ff <= 1'b0;
            pslverr_ff <= 1'b0;
            prdata_ff <= 32'h0000_0000;
        end else begin
            pready_ff <= psel && penable && !pready_ff;
            pslverr_ff <= psel && penable && !pready_ff && nxt_err;
            prdata_ff <= (psel && penable && !pready_ff && !pwrite) ? nxt_prdata
                : 32'h0000_0000;
        end
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            app_running_ff <= 1'b0;
            srm_clear_ff <= 1'b0;
            latch_ff <= '0;
            interval_ff <= REPORT_INTERVAL_CYCLES;
            text_lo_ff <= `SRM_TEXT_LO_RST;
            text_hi_ff <= `SRM_TEXT_HI_RST;
        end else begin
            srm_clear_ff <= wr_hit && paddr == `REG_CTRL && pwdata[`CTRL_SRM_CLEAR];
            // new alarm sets win over an acknowledge
            latch_ff <= (latch_ff & ~((wr_hit && paddr == `REG_ALARM_LATCH)
                ? pwdata[11:0] : 12'h000)) | alarm_evt_ff;
            if (wr_hit) begin
                case (paddr)
                    `REG_CTRL: app_running_ff <= pwdata[`CTRL_APP_RUNNING];
                    `REG_REPORT_INTERVAL: interval_ff <= pwdata;
                    `REG_SRM_TEXT_LO: text_lo_ff <= pwdata;
                    `REG_SRM_TEXT_HI: text_hi_ff <= pwdata[15:0];
                    default: ;
                endcase
            end
        end
    end

    assign leds = leds_ff;
    assign preset_safety_message = srm_ff;
    assign tx_inhibit = tx_inhibit_ff;
    assign alarm_event = alarm_evt_ff;
    assign serial_txd = txd_ff;
    assign prdata = prdata_ff;
    assign pready = pready_ff;
    assign pslverr = pslverr_ff;

    // assertions
    sequence fire_seq;
        srm_fire && !blue_ff && rate_cnt_ff == 24'h00_0000;
    endsequence

    chk_lamp_all_on: assert property (@(posedge clock) disable iff (!resetn)
        $rose(phase_ff == LAMP_ON2) |=> leds_ff == 4'hf)
        else $error("lamp test leds not all lit");
    chk_red_blue_off: assert property (@(posedge clock) disable iff (!resetn)
        $rose(phase_ff == RUN) && !blue_ff && !red_cond |=> !leds_ff.red && !leds_ff.blue)
        else $error("red or blue lit after lamp test");
    chk_yellow_startup: assert property (@(posedge clock) disable iff (!resetn)
        phase_ff == RUN && !startup_done_ff |=> leds_ff.yellow)
        else $error("yellow off during start-up");
    chk_green_app: assert property (@(posedge clock) disable iff (!resetn)
        leds_ff.green && phase_ff == RUN && $past(phase_ff == RUN)
        |-> $past(app_running_ff) && $past(startup_done_ff))
        else $error("green lit without running application");
    chk_red_follows: assert property (@(posedge clock) disable iff (!resetn)
        phase_ff == RUN ##1 phase_ff == RUN |-> leds_ff.red == $past(red_cond))
        else $error("red does not follow conditions");
    chk_inhibit_sensor: assert property (@(posedge clock) disable iff (!resetn)
        !mon_ff.gps_fix |=> tx_inhibit_ff)
        else $error("transmit not inhibited without fix");
    chk_srm_pulse: assert property (@(posedge clock) disable iff (!resetn)
        fire_seq |=> srm_ff.req ##1 !srm_ff.req && blue_ff)
        else $error("safety request not a single pulse");
    chk_srm_refused: assert property (@(posedge clock) disable iff (!resetn)
        blue_ff && !srm_clear_ff |=> !srm_ff.req)
        else $error("request accepted while blue lit");
    chk_srm_held: assert property (@(posedge clock) disable iff (!resetn)
        $rose(srm_ff.req) |-> $past(btn_ff) && $past(hold_cnt_ff) == SRM_HOLD_CYCLES)
        else $error("request without full hold");
    chk_alarm_event: assert property (@(posedge clock) disable iff (!resetn)
        $rose(alarm_ff[3]) |=> alarm_evt_ff[3] ##1 latch_ff[3])
        else $error("alarm event missing");

endmodule

`default_nettype wire

/* core/ais_status_defines.svh */
// constants for the status indicator and integrity monitor block
// assumes a 10 MHz system clock and an apb register port
`ifndef AIS_STATUS_DEFINES_SVH
`define AIS_STATUS_DEFINES_SVH

// clock and times in their own units
`define CLK_HZ 10000000
`define LAMP_MS 1000
`define SRM_HOLD_MS 2000
`define SRM_RATE_MS 1000
`define GPS_LOCK_MIN 30
`define REPORT_INTERVAL_MS 30000
`define BAUD_RATE 38400

// cycle counts derived from the times
`define LAMP_CYCLES ((`CLK_HZ / 1000) * `LAMP_MS)
`define SRM_HOLD_CYCLES ((`CLK_HZ / 1000) * `SRM_HOLD_MS)
`define SRM_RATE_CYCLES ((`CLK_HZ / 1000) * `SRM_RATE_MS)
`define GPS_LOCK_CYCLES (64'd60 * `CLK_HZ * `GPS_LOCK_MIN)
`define REPORT_INTERVAL_CYCLES ((`CLK_HZ / 1000) * `REPORT_INTERVAL_MS)
`define BIT_CYCLES (`CLK_HZ / `BAUD_RATE)

// register byte offsets
`define REG_CTRL 8'h00
`define REG_STATUS 8'h04
`define REG_ALARM_LATCH 8'h08
`define REG_REPORT_INTERVAL 8'h0c
`define REG_SRM_TEXT_LO 8'h10
`define REG_SRM_TEXT_HI 8'h14
`define REG_SRM_TYPE 8'h18

// control bit positions
`define CTRL_APP_RUNNING 0
`define CTRL_SRM_CLEAR 1

// status field positions
`define STATUS_STARTUP_DONE 12
`define STATUS_LED_LSB 16
`define STATUS_TX_INHIBIT 20

// reset values, message type and alarm letter base
`define SRM_TEXT_LO_RST 32'h4d41_5944
`define SRM_TEXT_HI_RST 16'h4159
`define SRM_MSG_TYPE 6'h0e
`define ALARM_CHAR_BASE 8'h41

`endif

/* core/ais_status_pkg.sv */
// types shared by the status indicator block
// assumes the defines header sits beside it
package ais_status_pkg;

    // conditioned monitor inputs, high means bad unless noted
    typedef struct packed {
        logic gps_fix;          // high when position is valid
        logic lockout_expired;
        logic supply_bad;
        logic noise_high;
        logic gps_fail;
        logic cog_invalid;
        logic sog_invalid;
        logic gnss_unused;
        logic mismatch_high;
        logic rx2_unlock;
        logic rx1_unlock;
        logic tx_unlock;
    } mon_s;

    typedef struct packed {
        logic blue;
        logic red;
        logic yellow;
        logic green;
    } led_s;

    typedef struct packed {
        logic req;
        logic [5:0] msg_type;
        logic [47:0] text;
    } srm_s;

    typedef logic [11:0] alarm_t;

    typedef enum logic [3:0] {
        LAMP_ON1 = 4'b0001,
        LAMP_OFF1 = 4'b0010,
        LAMP_ON2 = 4'b0100,
        RUN = 4'b1000
    } phase_e;

endpackage

/* testbench/panel_model.sv */
// panel side model: safety button and radio monitor pins
// assumes bench commands change just after the rising clock edge
`timescale 1ns/1ps
`default_nettype none

module panel_model
    import ais_status_pkg::*;
(
    input wire logic clock,
    input wire logic press_go,
    input wire logic [7:0] press_len,
    input wire mon_s fault_cmd,
    output logic srm_button,
    output mon_s monitor_pins
);
    logic [7:0] left_ff = 8'h00;
    mon_s pins_ff = '0;

    // button level held for the asked count, unrelated to device timing
    always @(posedge clock) begin
        if (press_go) begin
            left_ff <= press_len;
        end else if (left_ff != 8'h00) begin
            left_ff <= left_ff - 8'h01;
        end
    end
    assign srm_button = (left_ff != 8'h00);

    // monitor pins follow the asked fault pattern one edge later
    always @(posedge clock) begin
        pins_ff <= fault_cmd;
    end
    assign monitor_pins = pins_ff;
endmodule

`default_nettype wire

/* testbench/ais_status_indicator_monitor_test.sv */
// self-checking bench for the status indicator and integrity monitor
// assumes the panel model beside it and shortened counts on the design
`timescale 1ns/1ps
`default_nettype none

module ais_status_indicator_monitor_test
    import ais_status_pkg::*;
;
    logic clock = 1'b0;
    logic resetn = 1'b0;
    logic srm_button, press_go = 1'b0, report_sent = 1'b0, tx_blocked_busy = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00, press_len = 8'h00, byte_seen;
    logic [31:0] pwdata = 32'h0, prdata, rd_data, rnd;
    logic pready, pslverr, rd_err, tx_inhibit, serial_txd;
    mon_s fault_cmd = '0, monitor_pins;
    led_s leds;
    srm_s preset_safety_message, got_srm;
    alarm_t alarm_event, evt_seen = '0;
    int fail_count = 0, total_checks = 0, cycle_count = 0, req_count = 0, seed = 8913;

    always #50 clock = ~clock;

    ais_status_indicator_monitor #(
        .LAMP_CYCLES(24'h00_0014), .SRM_HOLD_CYCLES(25'h000_001e),
        .SRM_RATE_CYCLES(24'h00_0032), .GPS_LOCK_CYCLES(36'h0_0000_00c8),
        .REPORT_INTERVAL_CYCLES(32'h0010_0000)
    ) u_ais_status_indicator_monitor (
        .clock(clock), .resetn(resetn), .monitor_pins(monitor_pins),
        .srm_button(srm_button), .report_sent(report_sent),
        .tx_blocked_busy(tx_blocked_busy), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .leds(leds), .preset_safety_message(preset_safety_message),
        .tx_inhibit(tx_inhibit), .alarm_event(alarm_event), .serial_txd(serial_txd)
    );

    panel_model u_panel_model (
        .clock(clock), .press_go(press_go), .press_len(press_len),
        .fault_cmd(fault_cmd), .srm_button(srm_button), .monitor_pins(monitor_pins)
    );

    task automatic check(input string name, input logic [63:0] seen, input logic [63:0] exp);
        total_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic print_verdict();
        if (fail_count == 0 && total_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    function automatic logic exp_red(input int i);
        return i == 3 || i == 8 || i == 9 || i == 10;
    endfunction

    // apb transfer: setup, then access held until pready is sampled high
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clock);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        // wait for pready; the bench hang guard ends this wait only if pready never comes
        do begin
            @(posedge clock);
        end while (pready !== 1'b1);
        rd_data = prdata;
        rd_err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic look(input int n);
        repeat (n) @(posedge clock);
        @(negedge clock);
    endtask

    task automatic pulse(input logic busy);
        @(posedge clock);
        report_sent <= !busy;
        tx_blocked_busy <= busy;
        @(posedge clock);
        report_sent <= 1'b0;
        tx_blocked_busy <= 1'b0;
    endtask

    task automatic press(input logic [7:0] n);
        @(posedge clock);
        press_go <= 1'b1;
        press_len <= n;
        @(posedge clock);
        press_go <= 1'b0;
        repeat (n + 2) @(posedge clock);
    endtask

    // one serial frame: start, eight bits lsb first, stop
    task automatic uart_byte();
        int n = 0;
        while (serial_txd !== 1'b0 && n < 3000) begin
            @(negedge clock);
            n++;
        end
        repeat (130) @(negedge clock);
        check("start bit", serial_txd, 1'b0);
        for (int k = 0; k < 8; k++) begin
            repeat (260) @(negedge clock);
            byte_seen[k] = serial_txd;
        end
        repeat (260) @(negedge clock);
        check("stop bit", serial_txd, 1'b1);
    endtask

    // send pulse capture and hang guard
    always @(posedge clock) begin
        cycle_count++;
        evt_seen = evt_seen | alarm_event;
        if (preset_safety_message.req === 1'b1) begin
            req_count++;
            got_srm = preset_safety_message;
        end
        if (cycle_count > 40000) begin
            fail_count++;
            print_verdict();
        end
    end

    initial begin
        repeat (12) @(posedge clock);
        check("reset leds", {leds, preset_safety_message.req, tx_inhibit}, 6'h01);
        resetn <= 1'b1;
        // lamp test twice then red and blue out
        look(2);
        check("lamp on 1", leds, 4'hf);
        look(25);
        check("lamp off", leds, 4'h0);
        look(20);
        check("lamp on 2", leds, 4'hf);
        look(20);
        check("after lamp", leds, 4'h2);
        check("inhibit no fix", tx_inhibit, 1'b1);
        apb(1'b0, 8'h18, 32'h0);
        check("msg type", rd_data, 32'h0000_000e);
        apb(1'b0, 8'h10, 32'h0);
        check("text lo", rd_data, 32'h4d41_5944);
        apb(1'b0, 8'h40, 32'h0);
        check("unmapped", {rd_err, rd_data}, 33'h1_0000_0000);
        apb(1'b1, 8'h00, 32'h0000_0001);
        apb(1'b1, 8'h0c, 32'h0000_0028);
        apb(1'b0, 8'h0c, 32'h0);
        check("interval", rd_data, 32'h0000_0028);
        // report without fix, then lock timeout
        pulse(1'b0);
        look(5);
        check("yellow no fix", leds.yellow, 1'b1);
        check("green no fix", leds.green, 1'b0);
        look(150);
        check("red no lock", leds.red, 1'b1);
        @(posedge clock);
        fault_cmd <= 12'h800;
        look(10);
        check("red lock", leds.red, 1'b0);
        check("inhibit fix", tx_inhibit, 1'b0);
        check("still start", leds.yellow, 1'b1);
        pulse(1'b0);
        look(5);
        check("started", leds, 4'h1);
        look(60);
        check("one interval", leds.yellow, 1'b0);
        look(30);
        check("two missed", leds.yellow, 1'b1);
        pulse(1'b0);
        look(5);
        check("resumed", leds.yellow, 1'b0);
        apb(1'b1, 8'h0c, 32'h0010_0000);
        pulse(1'b1);
        look(5);
        check("busy", leds.yellow, 1'b1);
        pulse(1'b0);
        look(5);
        check("busy gone", leds.yellow, 1'b0);
        @(posedge clock);
        fault_cmd <= 12'h000;
        look(8);
        check("fix lost", {tx_inhibit, leds.yellow}, 2'h3);
        @(posedge clock);
        fault_cmd <= 12'h800;
        look(8);
        check("fix back", tx_inhibit, 1'b0);
        apb(1'b1, 8'h00, 32'h0);
        look(3);
        check("no app", leds.green, 1'b0);
        apb(1'b1, 8'h00, 32'h0000_0001);
        look(3000);
        apb(1'b1, 8'h08, 32'h0000_0fff);
        for (int i = 0; i < 11; i++) begin
            @(posedge clock);
            fault_cmd <= 12'h800 | (12'h001 << i);
            if (i == 0) begin
                uart_byte();
                check("alarm char", byte_seen, 8'h41);
            end else begin
                look(8);
            end
            check("red on", leds.red, exp_red(i));
            apb(1'b0, 8'h08, 32'h0);
            check("latch", rd_data, 32'h0000_0001 << i);
            check("event", evt_seen, 12'h800 | ((12'h002 << i) - 12'h001));
            apb(1'b1, 8'h08, 32'h0000_0001 << i);
            @(posedge clock);
            fault_cmd <= 12'h800;
            look(8);
            check("red off", leds.red, 1'b0);
        end
        // button hold, refusal while lit, rate limit
        press(8'h14);
        check("short hold", req_count, 0);
        press(8'h28);
        look(3);
        check("long hold", req_count, 1);
        check("msg", {got_srm.msg_type, got_srm.text}, {6'h0e, 48'h4d41_5944_4159});
        check("blue on", leds.blue, 1'b1);
        press(8'h28);
        check("blue refuses", req_count, 1);
        rnd = $random(seed);
        apb(1'b1, 8'h10, rnd);
        apb(1'b1, 8'h00, 32'h0000_0003);
        look(3);
        check("blue cleared", leds.blue, 1'b0);
        press(8'h24);
        check("resend", req_count, 2);
        check("new text", got_srm.text, {rnd, 16'h4159});
        apb(1'b1, 8'h00, 32'h0000_0003);
        press(8'h24);
        check("rate limit", req_count, 2);
        // a second reset silences the outputs
        @(posedge clock);
        resetn <= 1'b0;
        look(2);
        check("reset again", {leds, preset_safety_message.req, tx_inhibit}, 6'h01);
        print_verdict();
    end
endmodule

`default_nettype wire
